//--- hw/fcu_char_tx.sv
// Purpose: single character serial transmitter with a circulating 17-bit frame
// Assumes: APB slave on mclk, one frame bit per mclk, sync active low nrst
// Notes: characters queue in a 16 entry fifo; load mode drains it into the select
//
// Operation
// - frame: 4 idle, start, 8 data, stop, 3 idle
// - character 0x40..0x5F, select gives low five bits
// - select bit 0 is character bit 0
// - control low loads, high shifts the frame
// - serial line driven only while enabled
// - one frame bit per clock cycle
// - transmit mode recirculates the same frame
// - indicators show control and output enable
//
// The APB register port and the address map are this design's own decisions.
`default_nettype none

module fcu_char_tx (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fcu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // serial line
    output logic tx_out,
    output logic tx_oe,
    // indicators
    output logic seg_a,
    output logic seg_f
);

    // whole transmitter state
    typedef struct packed {
        fcu_pkg::fcu_mode_t mode; // load or transmit
        logic oe; // output enable
        logic [fcu_pkg::SEL_W-1:0] sel; // character select
        logic [fcu_pkg::FRAME_W-1:0] frame; // circulating frame
        logic [fcu_pkg::PHASE_W-1:0] phase; // frame bit position
        logic tx; // registered line bit
        logic [31:0] rdata; // read data, captured in setup
    } fcu_tx_state_t;

    fcu_tx_state_t s;
    fcu_tx_state_t next_s;

    // fifo link
    fcu_fifo_if #(.WIDTH(fcu_pkg::SEL_W), .LVL_W(fcu_pkg::FIFO_LVL_W)) fq ();

    fcu_fifo #(
        .WIDTH(fcu_pkg::SEL_W),
        .DEPTH(fcu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .nrst(nrst),
        .port(fq.store)
    );

    // decode helpers
    logic access; // apb access phase
    logic hit_ctrl; // control register
    logic hit_char; // character queue
    logic hit_stat; // status register
    logic hit_frame; // frame view
    logic mapped; // any register hit
    logic wr_done; // write takes effect this edge
    logic wr_ctrl; // control write takes effect
    logic [31:0] rd_mux; // read value for current address
    logic [7:0] cur_char; // full character code

    assign access = psel & penable;

    // address decode
    // only the four word offsets hit; any other address is refused with pslverr
    // the decode runs on paddr alone, psel and penable qualify it further on
    always_comb begin
        hit_ctrl = 1'b0;
        hit_char = 1'b0;
        hit_stat = 1'b0;
        hit_frame = 1'b0;
        if (paddr == fcu_pkg::ADDR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (paddr == fcu_pkg::ADDR_CHAR) begin
            hit_char = 1'b1;
        end else if (paddr == fcu_pkg::ADDR_STAT) begin
            hit_stat = 1'b1;
        end else if (paddr == fcu_pkg::ADDR_FRAME) begin
            hit_frame = 1'b1;
        end
    end

    assign mapped = hit_ctrl | hit_char | hit_stat | hit_frame;

    // a character write waits while the fifo is full
    assign pready = (access & pwrite & hit_char) ? fq.in_ready : 1'b1;
    assign pslverr = access & ~mapped;
    assign wr_done = access & pready & pwrite & mapped;
    assign wr_ctrl = wr_done & hit_ctrl;
    assign prdata = s.rdata;

    // fifo fill from writes, drain only in load mode
    assign fq.in_valid = access & pwrite & hit_char;
    assign fq.in_data = pwdata[fcu_pkg::SEL_W-1:0];
    assign fq.out_ready = (s.mode == fcu_pkg::FCU_MODE_LOAD);

    // upper bits fixed, select on the low bits
    assign cur_char = {fcu_pkg::CHAR_HI, s.sel};

    // read value mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = {30'h0, s.oe, s.mode};
        end else if (hit_char) begin
            rd_mux = {24'h0, cur_char};
        end else if (hit_stat) begin
            rd_mux = {18'h0, s.phase, s.tx, s.mode, fq.level, ~fq.in_ready, ~fq.out_valid};
        end else if (hit_frame) begin
            rd_mux = {15'h0, s.frame};
        end
    end

    // next state of the transmitter
    // load mode keeps rebuilding the frame from the select, so the frame is
    // always ready when software flips to transmit; transmit mode only rotates,
    // which is what makes the same character go out again and again
    // the phase counter is kept only for status and checks, it steers nothing
    always_comb begin
        next_s = s;
        // control write: mode and output enable
        if (wr_ctrl) begin
            next_s.mode = fcu_pkg::fcu_mode_t'(pwdata[fcu_pkg::CTRL_TX_BIT]);
            next_s.oe = pwdata[fcu_pkg::CTRL_OE_BIT];
        end
        // read data captured in the setup cycle
        if (psel && !penable) begin
            next_s.rdata = rd_mux;
        end
        case (s.mode)
            fcu_pkg::FCU_MODE_LOAD: begin
                // take a queued select, then rebuild the frame
                if (fq.out_valid) begin
                    next_s.sel = fq.out_data;
                end
                next_s.frame = fcu_pkg::fcu_build_frame(next_s.sel);
                next_s.phase = '0;
            end
            fcu_pkg::FCU_MODE_TX: begin
                // rotate right one bit per clock, bit 0 goes out
                next_s.frame = {s.frame[0], s.frame[fcu_pkg::FRAME_W-1:1]};
                if (s.phase == fcu_pkg::PHASE_W'(fcu_pkg::FRAME_W - 1)) begin
                    next_s.phase = '0;
                end else begin
                    next_s.phase = s.phase + 1'b1;
                end
            end
            default: begin
                next_s.mode = fcu_pkg::FCU_MODE_LOAD;
            end
        endcase
        // line bit follows frame bit 0
        next_s.tx = s.frame[0];
        // synchronous reset
        if (!nrst) begin
            next_s = '0;
            next_s.mode = fcu_pkg::FCU_MODE_LOAD;
            next_s.sel = fcu_pkg::SEL_RESET;
            next_s.frame = fcu_pkg::fcu_build_frame(fcu_pkg::SEL_RESET);
            next_s.tx = fcu_pkg::LINE_IDLE;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    // line and indicators
    assign tx_out = s.tx;
    assign tx_oe = s.oe;
    assign seg_a = (s.mode == fcu_pkg::FCU_MODE_TX);
    assign seg_f = s.oe;

    // checks
    // all properties sample on mclk and are quiet while nrst is low
    // phase counts frame bits from the first transmit cycle, so phase p
    // puts frame bit p on the line one cycle later
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence in_load_s;
        s.mode == fcu_pkg::FCU_MODE_LOAD;
    endsequence

    sequence in_tx_s;
        s.mode == fcu_pkg::FCU_MODE_TX;
    endsequence

    sequence tx_two_s;
        in_tx_s ##1 in_tx_s;
    endsequence

    frame_shape_a: assert property (
        in_load_s |=> (s.frame[3:0] == fcu_pkg::IDLE_LEAD_BITS)
            && (s.frame[fcu_pkg::START_POS] == fcu_pkg::START_BIT)
            && (s.frame[fcu_pkg::STOP_POS] == fcu_pkg::STOP_BIT)
            && (s.frame[16:14] == fcu_pkg::IDLE_TAIL_BITS))
        else $error("frame layout wrong after load");

    char_range_a: assert property (
        in_load_s ##1 in_load_s |-> (s.frame[12:5] >= fcu_pkg::CHAR_MIN)
            && (s.frame[12:5] <= fcu_pkg::CHAR_MAX))
        else $error("character outside range");

    select_a_a: assert property (
        (in_load_s and (next_s.sel == 5'h01)) |=> s.frame[12:5] == 8'h41)
        else $error("select one does not give A");

    start_shift_a: assert property (
        $rose(s.mode == fcu_pkg::FCU_MODE_TX) |-> (s.phase == 5'h00) ##1 (s.phase == 5'h01))
        else $error("shifting did not start at frame bit zero");

    oe_drive_a: assert property (
        wr_ctrl |=> (tx_oe == $past(pwdata[fcu_pkg::CTRL_OE_BIT])) && (seg_f == tx_oe))
        else $error("output enable not applied");

    bit_rate_a: assert property (
        tx_two_s |=> tx_out == $past(s.frame[1], 2))
        else $error("line not one bit per clock");

    recirc_a: assert property (
        in_tx_s [*8] ##1 in_tx_s [*8] ##1 in_tx_s |=> s.frame == $past(s.frame, 17))
        else $error("frame not recirculated");

    seg_track_a: assert property (
        $changed(seg_a) |-> $past(wr_ctrl))
        else $error("indicator moved without control write");

    start_low_a: assert property (
        (in_tx_s and (s.phase == 5'h04)) |=> tx_out == fcu_pkg::START_BIT)
        else $error("start bit not low");

    // stop bit follows the last data bit
    stop_high_a: assert property (
        (in_tx_s and (s.phase == 5'h0D)) |=> tx_out == fcu_pkg::STOP_BIT)
        else $error("stop bit not high");

    // first frame bit is idle
    lead_idle_a: assert property (
        (in_tx_s and (s.phase == 5'h00)) |=> tx_out == fcu_pkg::LINE_IDLE)
        else $error("leading idle bit not high");

    // first data bit is select bit 0
    data_lsb_a: assert property (
        (in_tx_s and (s.phase == 5'h05)) |=> tx_out == $past(s.sel[0]))
        else $error("data not sent lsb first");

    // line rests high while loading
    load_idle_a: assert property (
        in_load_s ##1 in_load_s |=> tx_out == fcu_pkg::LINE_IDLE)
        else $error("line not idle in load mode");

    // select frozen while transmitting
    sel_hold_a: assert property (
        in_tx_s |=> s.sel == $past(s.sel))
        else $error("select changed in transmit");

    // phase stays inside the frame
    phase_bound_a: assert property (
        s.phase <= 5'h10)
        else $error("phase beyond frame");

    // phase wraps after the last bit
    phase_wrap_a: assert property (
        (in_tx_s and (s.phase == 5'h10)) |=> s.phase == 5'h00)
        else $error("phase did not wrap");

    // mode indicator tracks the mode
    seg_mode_a: assert property (
        seg_a == (s.mode == fcu_pkg::FCU_MODE_TX))
        else $error("mode indicator wrong");

    // enable indicator tracks the enable
    seg_oe_a: assert property (
        seg_f == tx_oe)
        else $error("enable indicator wrong");

endmodule : fcu_char_tx

`default_nettype wire

//--- hw/fcu_pkg.sv
// Purpose: shared constants, types and frame builder for the fixed frame character transmitter
// Assumes: one clock (mclk), synchronous active low reset
// Notes: register map is word aligned, 32-bit data, byte addresses below
`default_nettype none

package fcu_pkg;

    // clock and line rate: one frame bit per clock cycle
    localparam int CLK_HZ = 125_000_000;
    localparam int BIT_CYCLES = 1;
    localparam int BAUD = CLK_HZ / BIT_CYCLES;

    // frame layout, bit 0 leaves the line first
    localparam int FRAME_W = 17;
    localparam int IDLE_LEAD = 4;
    localparam int DATA_W = 8;
    localparam int IDLE_TAIL = 3;
    localparam int START_POS = 4;
    localparam int DATA_POS = 5;
    localparam int STOP_POS = 13;
    localparam int TAIL_POS = 14;
    localparam logic [IDLE_LEAD-1:0] IDLE_LEAD_BITS = 4'hF;
    localparam logic [IDLE_TAIL-1:0] IDLE_TAIL_BITS = 3'h7;
    localparam logic START_BIT = 1'h0;
    localparam logic STOP_BIT = 1'h1;
    localparam logic LINE_IDLE = 1'h1;

    // character select: low five bits from software, upper bits fixed
    localparam int SEL_W = 5;
    localparam logic [2:0] CHAR_HI = 3'h2;
    localparam logic [7:0] CHAR_MIN = 8'h40;
    localparam logic [7:0] CHAR_MAX = 8'h5F;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;

    // character fifo
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_LVL_W = 5;

    // register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CHAR = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FRAME = 8'h0C;
    localparam int CTRL_TX_BIT = 0;
    localparam int CTRL_OE_BIT = 1;
    localparam int PHASE_W = 5;

    // operating mode of the shift register
    typedef enum logic [0:0] {
        FCU_MODE_LOAD = 1'b0,
        FCU_MODE_TX = 1'b1
    } fcu_mode_t;

    // build the circulating frame for a five-bit select
    function automatic logic [FRAME_W-1:0] fcu_build_frame(input logic [SEL_W-1:0] sel);
        logic [DATA_W-1:0] ch;
        ch = {CHAR_HI, sel};
        return {IDLE_TAIL_BITS, STOP_BIT, ch, START_BIT, IDLE_LEAD_BITS};
    endfunction

endpackage : fcu_pkg

`default_nettype wire

//--- hw/fcu_fifo_if.sv
// Purpose: carrier between the transmitter core and its character fifo
// Assumes: valid/ready handshake on both sides, same clock
// Notes: level counts stored entries
`default_nettype none

interface fcu_fifo_if #(
    parameter int WIDTH = 5,
    parameter int LVL_W = 5
);
    logic in_valid; // fill side offers a word
    logic in_ready; // fifo has room
    logic [WIDTH-1:0] in_data; // word offered
    logic out_valid; // fifo holds a word
    logic out_ready; // drain side takes the word
    logic [WIDTH-1:0] out_data; // head word
    logic [LVL_W-1:0] level; // entries held

    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, level
    );
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data, level
    );
endinterface : fcu_fifo_if

`default_nettype wire

//--- hw/fcu_fifo.sv
// Purpose: flip-flop fifo for selected characters
// Assumes: DEPTH is a power of two, so pointers wrap by overflow
// Notes: push and pop may happen in the same cycle
`default_nettype none

module fcu_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // both handshake sides
    fcu_fifo_if.store port
);
    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);
    localparam logic [LW-1:0] FULL_LVL = LW'(DEPTH);

    // whole fifo state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
        logic [PW-1:0] wp; // write index
        logic [PW-1:0] rp; // read index
        logic [LW-1:0] cnt; // entries held
    } fcu_fifo_state_t;

    fcu_fifo_state_t s;
    fcu_fifo_state_t next_s;
    logic push; // accepted write
    logic pop; // accepted read

    // handshake flags, honest full and empty
    assign port.in_ready = (s.cnt != FULL_LVL);
    assign port.out_valid = (s.cnt != '0);
    assign port.out_data = s.mem[s.rp];
    assign port.level = s.cnt;
    assign push = port.in_valid & port.in_ready;
    assign pop = port.out_valid & port.out_ready;

    // next state
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wp] = port.in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop) begin
            next_s.rp = s.rp + 1'b1;
        end
        next_s.cnt = s.cnt + LW'(push) - LW'(pop);
        if (!nrst) begin
            next_s = '0;
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    // level never exceeds depth
    level_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
        s.cnt <= FULL_LVL) else $error("fifo level above depth");
    // a lone push raises level by one
    level_step_a: assert property (@(posedge mclk) disable iff (!nrst)
        (push && !pop) |=> s.cnt == $past(s.cnt) + 1'b1) else $error("fifo level step");

endmodule : fcu_fifo

`default_nettype wire

//--- verification/fcu_rx_model.sv
// Purpose: serial receiver on the far side of the line
// Assumes: one bit per mclk, line pulled high when released
// Notes: counts frames with a good stop bit, keeps the last character
`default_nettype none

module fcu_rx_model (
    // clock
    input wire logic mclk,
    // resolved serial line
    input wire logic line,
    // decoded result
    output var logic [7:0] rx_char,
    output var int rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    int left; // bits still to take
    logic [8:0] sh; // data then stop

    // quiet start values
    initial begin
        left = 0;
        rx_count = 0;
        rx_char = 8'h00;
        sh = 9'h000;
    end

    // one sample per clock: start low, 8 data lsb first, stop high
    always @(posedge mclk) begin
        if (left == 0) begin
            if (line === 1'b0) left <= 9;
        end else begin
            sh <= {line, sh[8:1]};
            left <= left - 1;
            // good stop bit ends a frame
            if (left == 1 && line === 1'b1) begin
                rx_char <= sh[8:1];
                rx_count <= rx_count + 1;
            end
        end
    end
endmodule // fcu_rx_model

`default_nettype wire

//--- verification/tb_fixed_frame_uart_char_tx.sv
// Purpose: self-checking bench for the character transmitter
// Assumes: apb master on an 8 ns mclk, receiver model on the line
// Notes: table rows first, then enable, error, fifo and reset cases
`default_nettype none

module tb_fixed_frame_uart_char_tx;
    timeunit 1ns;
    timeprecision 1ps;
    // dut pins
    logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
    logic tx_out, tx_oe, seg_a, seg_f;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    // bench state
    logic [31:0] r; // last read data
    logic e; // last error flag
    logic [7:0] rx_char;
    logic [16:0] fr;
    int rx_count, miscompares, num_checks, c0;
    logic [4:0] sel_tab [4] = '{5'h00, 5'h01, 5'h1A, 5'h1F}; // select in
    logic [7:0] chr_tab [4] = '{8'h40, 8'h41, 8'h5A, 8'h5F}; // char out
    wire logic line = (tx_oe === 1'b1) ? tx_out : 1'b1; // pulled high

    fcu_char_tx i_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .tx_out(tx_out), .tx_oe(tx_oe),
        .seg_a(seg_a), .seg_f(seg_f));
    fcu_rx_model i_rx (.mclk(mclk), .line(line), .rx_char(rx_char), .rx_count(rx_count));

    // clock source
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    // verdict and end of run
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1, "apb hang");
    endtask

    // sync on a start bit, then follow a whole frame to the next start
    task line_chk(input logic [16:0] f);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (tx_out !== 1'b0 && n < 60);
        chk(n < 60, 1'h1, "no start");
        for (int j = 1; j <= 17; j++) begin
            @(posedge mclk);
            chk(tx_out, f[(4+j)%17], "line bit");
        end
    endtask

    // expected frame from the framing rules
    function automatic logic [16:0] frame_of(input logic [7:0] c);
        return {3'h7, 1'h1, c, 1'h0, 4'hF};
    endfunction

    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        $display("mismatch at %0t: timeout", $time);
        close_out();
    end

    // main sequence
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        // table rows: select in, character and frame out
        for (int i = 0; i < 4; i++) begin
            fr = frame_of(chr_tab[i]);
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h04, {27'h0, sel_tab[i]});
            repeat (4) @(posedge mclk);
            apb(1'b0, 8'h04, 32'h0);
            chk(r, {24'h0, chr_tab[i]}, "char");
            apb(1'b0, 8'h0C, 32'h0);
            chk(r, {15'h0, fr}, "frame");
            c0 = rx_count;
            apb(1'b1, 8'h00, 32'h3);
            line_chk(fr);
            chk({seg_a, seg_f, tx_oe}, 3'h7, "indicators");
            repeat (20) @(posedge mclk);
            chk(rx_char, chr_tab[i], "rx char");
            chk(rx_count >= c0 + 2, 1'h1, "repeat");
            $display("row %0d done", i);
        end
        // transmit with the line released
        apb(1'b1, 8'h00, 32'h1);
        repeat (20) @(posedge mclk);
        c0 = rx_count;
        repeat (40) @(posedge mclk);
        chk({seg_a, seg_f, tx_oe, 29'h0}, 32'h80000000, "oe off");
        chk(rx_count, c0, "quiet line");
        // load mode holds the line idle
        apb(1'b1, 8'h00, 32'h2);
        repeat (2) @(posedge mclk);
        for (int k = 0; k < 20; k++) begin
            @(posedge mclk);
            chk({seg_a, seg_f, line}, 3'h3, "load idle");
        end
        $display("enable test done");
        // unmapped address
        apb(1'b0, 8'h10, 32'h0);
        chk({e, r[30:0]}, 32'h80000000, "unmapped");
        // fifo filled in transmit, drained in load
        apb(1'b1, 8'h00, 32'h1);
        for (int k = 0; k < 16; k++) apb(1'b1, 8'h04, k);
        apb(1'b0, 8'h08, 32'h0);
        chk(r[7:0], 8'hC2, "fifo full");
        apb(1'b1, 8'h00, 32'h0);
        repeat (30) @(posedge mclk);
        apb(1'b0, 8'h08, 32'h0);
        chk(r[6:0], 7'h01, "fifo empty");
        apb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h4F, "last char");
        $display("fifo test done");
        // reset in mid transmit
        apb(1'b1, 8'h00, 32'h3);
        repeat (10) @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        chk({tx_out, tx_oe, seg_a, seg_f}, 4'h8, "reset pins");
        apb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h40, "reset char");
        $display("reset test done");
        close_out();
    end
endmodule // tb_fixed_frame_uart_char_tx

`default_nettype wire
